// File: adc_scan_buffer_sequencer_bench.sv
// self-checking bench for the scan sequencer with a converter model
// assumes 25 MHz clock, reset held 3 cycles
`timescale 1ns/1ps
`default_nettype none

module adc_scan_buffer_sequencer_bench;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, slow = 0;
  logic        external_start_n = 1, conv_start, conv_gain_x10, conv_done;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, conv_data, v;
  logic [15:0] seed = 16'h878c;
  logic [5:0]  conv_channel;
  logic [63:0] gtab;
  int failures = 0, tests_run = 0, nstart = 0, ndone = 0, cyc = 0, n0;

  always #20 clk = ~clk;

  adcsq_sequencer i_adcsq_sequencer (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .conv_start, .conv_channel,
    .conv_gain_x10, .conv_done, .conv_data, .external_start_n);
  adcsq_conv_model i_adcsq_conv_model (.clk, .rst, .conv_start,
    .conv_channel, .conv_gain_x10, .slow, .conv_done, .conv_data);

  always @(posedge clk) begin
    cyc++;
    nstart += int'(conv_start === 1'b1);
    ndone += int'(conv_done === 1'b1);
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] exp_word(input logic [5:0] ch,
                                           input logic g, input logic tc);
    return {ch, g, 9'h0a5} ^ {tc, 15'h0000};
  endfunction : exp_word

  task automatic chk(input logic [15:0] exp, input logic [15:0] got,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  task automatic wait_done(input int n);
    int t, i;
    t = ndone + n;
    for (i = 0; i < 4000 && ndone < t; i++) @(posedge clk);
    chk(16'(t), 16'(ndone), "conversions");
  endtask : wait_done

  // reads the 16-word buffer of the 8-channel block on channels 16..23
  task automatic chk_buf(input logic g, input logic tc, input logic ag);
    int i;
    logic [5:0] ch;
    for (i = 0; i < 16; i++) begin
      ch = 6'h10 | 6'(i & 7);
      rd(16'h0080 + 16'(2 * i));
      chk(exp_word(ch, ag ? gtab[ch] : g, tc), v, "buffer word");
    end
  endtask : chk_buf

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial begin
    logic [15:0] a, d;
    int i, k;
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(16'h0002);
    chk(16'h8000, v, "control reset");
    rd(16'h0004);
    chk(16'h5800, v, "config reset");
    rd(16'h0001);
    chk(16'h0000, v, "odd address");
    wr(16'h0006, 16'h0010 + (rnd() & 16'h000f));
    for (k = 0; k < 4; k++) begin
      slow <= 1'(rnd() & 16'h0001);
      wr(16'h0002, 16'h8000 | 16'(k & 1) << 14);
      wr(16'h0004, 16'h001a | 16'(k >> 1) << 8);
      wait_done(20);
      chk_buf(k[1], k[0], 0);
    end
    for (i = 0; i < 4; i++) begin
      a = i == 0 ? 16'h0ffe : i == 1 ? 16'h00a0 :
          16'h0880 + ((rnd() % 16'h03c0) << 1);
      d = rnd();
      wr(a, d);
      rd(a);
      chk(d, v, "scratch");
    end
    gtab = {rnd(), rnd(), rnd(), rnd()};
    for (i = 16; i < 24; i++) wr(16'h1000 + 16'(2 * i), {15'h0, gtab[i]});
    wr(16'h0004, 16'h021a);
    wait_done(20);
    chk_buf(0, 1, 1);
    wr(16'h0004, 16'h005a);
    wr(16'h0002, 16'h8080);
    rd(16'h0002);
    chk(16'h0040, v & 16'h00c0, "ready cleared");
    for (i = 0; i < 16; i++) wr(16'h0080 + 16'(2 * i), 16'h0000);
    n0 = nstart;
    wr(16'h000e, rnd());
    wait_done(4);
    wr(16'h000e, rnd());
    wait_done(12);
    repeat (300) @(posedge clk);
    chk(16'h0010, 16'(nstart - n0), "single scan starts");
    chk_buf(0, 0, 0);
    rd(16'h0002);
    chk(16'h00c0, v & 16'h00c0, "idle and ready");
    wr(16'h0002, 16'h9000);
    n0 = nstart;
    wr(16'h000e, rnd());
    repeat (300) @(posedge clk);
    chk(16'h0000, 16'(nstart - n0), "unarmed start");
    @(posedge clk);
    external_start_n <= 0;
    repeat (7) @(posedge clk);
    external_start_n <= 1;
    wait_done(16);
    repeat (300) @(posedge clk);
    chk(16'h0010, 16'(nstart - n0), "external scan starts");
    wr(16'h0020, 16'h00c8);
    wr(16'h0002, 16'ha000);
    wait_done(32);
    report_and_stop();
  end
endmodule : adc_scan_buffer_sequencer_bench
`default_nettype wire

// File: adcsq_conv_model.sv
// behavioural converter answering launches after a short or long delay
// assumes launches come on clk; data depends on channel and gain only
`timescale 1ns/1ps
`default_nettype none

module adcsq_conv_model (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // launch
  input wire logic         conv_start,
  input wire logic  [5:0]  conv_channel,
  input wire logic         conv_gain_x10,
  input wire logic         slow,
  // result
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  logic [4:0]  cnt;
  logic [15:0] val;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt       <= 5'h00;
      conv_done <= 1'b0;
      val       <= 16'h0000;
    end else begin
      conv_done <= cnt == 5'h01;
      if (conv_start) begin
        cnt <= slow ? 5'h0c : 5'h02;
        val <= {conv_channel, conv_gain_x10, 9'h0a5};
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
  // no stale value outside the strobe
  assign conv_data = conv_done ? val : ~val ^ {cnt, 11'h000};
endmodule : adcsq_conv_model
`default_nettype wire

// File: adcsq_pkg.sv
// constants, field layouts and decode helpers for the scan sequencer
// assumes a 25 MHz system clock and 16-bit byte-addressed registers

package adcsq_pkg;

  // ***********************************
  // timing
  // ***********************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int DEF_RATE_HZ = 100_000;
  localparam logic [15:0] DEF_PACE = 16'(CLK_HZ / DEF_RATE_HZ);
  localparam int CLK_NS      = 40;
  localparam int TMR_TICK_NS = 160;
  localparam logic [2:0] TMR_PRESC = 3'(TMR_TICK_NS / CLK_NS);

  // ***********************************
  // register map (byte offsets)
  // ***********************************
  localparam logic [15:0] OFS_CSR   = 16'h0002;
  localparam logic [15:0] OFS_CCR   = 16'h0004;
  localparam logic [15:0] OFS_RATE  = 16'h0006;
  localparam logic [15:0] OFS_START = 16'h000e;
  localparam logic [15:0] OFS_TIMER = 16'h0020;
  localparam logic [8:0]  GAIN_PAGE = 9'h020;
  localparam logic [10:0] BUF_BASE_W = 11'h040;
  localparam logic [4:0]  LOW_PAGE  = 5'h00;
  localparam logic [3:0]  RAM_TOP   = 4'h0;
  localparam logic [15:0] CSR_RST   = 16'h8000;
  localparam logic [15:0] CCR_RST   = 16'h5800;
  localparam logic [15:0] MSB_FLIP  = 16'h8000;

  // ***********************************
  // fields
  // ***********************************
  localparam int CSR_CODE = 14;
  localparam int CSR_TMR  = 13;
  localparam int CSR_EXT  = 12;
  localparam int CSR_RDY  = 7;
  localparam int CSR_IDLE = 6;
  localparam int CCR_AGAIN = 9;
  localparam int CCR_X10   = 8;
  localparam int CCR_MODE_LO = 6;
  localparam int CCR_BLK_LO  = 3;
  localparam int CCR_GRP_LO  = 0;
  localparam int CCR_BUF_LO  = 13;

  localparam logic [1:0] MODE_AUTO   = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [2:0] BUF_MAX_CODE = 3'h6;
  localparam logic [10:0] BUF_MIN_W  = 11'h010;
  localparam logic [9:0]  BUF_MAX_L  = 10'h3ff;

  typedef enum logic [1:0] {
    TRG_SW  = 2'b00,
    TRG_EXT = 2'b01,
    TRG_TMR = 2'b10
  } adcsq_trig_t;

  // last word index of the buffer for a length code
  function automatic logic [9:0] buf_last(input logic [2:0] c);
    if (c >= BUF_MAX_CODE) begin
      buf_last = BUF_MAX_L;
    end else begin
      buf_last = 10'((BUF_MIN_W << c) - 11'h001);
    end
  endfunction : buf_last

  // channel offset mask for a block size code
  function automatic logic [5:0] blk_mask(input logic [2:0] c);
    unique case (c)
      3'h0:    blk_mask = 6'h3f;
      3'h1:    blk_mask = 6'h1f;
      3'h2:    blk_mask = 6'h0f;
      3'h3:    blk_mask = 6'h07;
      default: blk_mask = 6'h00;
    endcase
  endfunction : blk_mask

endpackage : adcsq_pkg

// File: adcsq_seq_properties.sv
// concurrent checks on the scan sequencer's ports
// assumes one clock and a bench keeping the pace register at 16 or more
`timescale 1ns/1ps
`default_nettype none

module adcsq_seq_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // converter
  input wire logic        conv_start,
  input wire logic [5:0]  conv_channel,
  input wire logic        conv_gain_x10,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  // trigger pin
  input wire logic        external_start_n
);
  // ***********************************
  // configuration shadow
  // ***********************************
  logic [15:0] ccr_sh;
  logic [3:0]  since_ccr;
  logic [5:0]  blk_msk;
  logic [5:0]  first_ch;
  logic        ccr_hit;
  assign ccr_hit  = reg_wr && reg_addr == adcsq_pkg::OFS_CCR;
  assign blk_msk  = ccr_sh[5:3] == 3'h0 ? 6'h3f : ccr_sh[5:3] == 3'h1 ? 6'h1f :
                    ccr_sh[5:3] == 3'h2 ? 6'h0f : ccr_sh[5:3] == 3'h3 ? 6'h07 :
                    6'h00;
  assign first_ch = {ccr_sh[2:0], 3'h0} & ~blk_msk;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ccr_sh    <= 16'h5800;
      since_ccr <= 4'hf;
    end else begin
      if (ccr_hit) ccr_sh <= reg_wdata;
      if (ccr_hit) since_ccr <= 4'h0;
      else if (since_ccr != 4'hf) since_ccr <= since_ccr + 4'h1;
    end
  end

  // ***********************************
  // assertions
  // ***********************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  rdata_quiet_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
  odd_zero_a: assert property (
    reg_rd && reg_addr[0] |=> reg_rdata == 16'h0000) else $error("odd read not zero");
  start_pulse_a: assert property (
    conv_start |=> !conv_start) else $error("start longer than one cycle");
  pace_gap_a: assert property (
    conv_start |=> (!conv_start || since_ccr < 4'h6) [*8]) else $error("starts too close");
  done_gap_a: assert property (
    conv_done && since_ccr > 4'h5 |=> !conv_start) else $error("start right after done");
  chan_hold_a: assert property (
    !conv_start |-> $stable(conv_channel) && $stable(conv_gain_x10))
    else $error("channel or gain moved");
  fixed_gain_a: assert property (
    conv_start && since_ccr != 4'h0 && !ccr_sh[9] |-> conv_gain_x10 == ccr_sh[8])
    else $error("fixed gain wrong");
  chan_group_a: assert property (
    conv_start && since_ccr != 4'h0 |-> (conv_channel & ~blk_msk) == first_ch)
    else $error("channel outside block");
  reset_auto_a: assert property (
    $fell(rst) |-> ##[0:3] conv_start) else $error("no scan after reset");

  cover property (conv_done);
  cover property (ccr_hit && reg_wdata[6]);
  cover property ($fell(external_start_n));
endmodule : adcsq_seq_properties

bind adcsq_sequencer adcsq_seq_properties i_adcsq_seq_properties (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_start,
  .conv_channel, .conv_gain_x10, .conv_done, .conv_data, .external_start_n);
`default_nettype wire

// File: adcsq_sequencer.sv
// scan buffer sequencer: registers, on-board RAM, gain RAM, scan control
// assumes a converter on clk taking conv_start and answering conv_done
// with raw offset binary data in the same cycle as conv_done
`timescale 1ns/1ps
`default_nettype none

module adcsq_sequencer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // converter
  output logic             conv_start,
  output logic      [5:0]  conv_channel,
  output logic             conv_gain_x10,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  // trigger pin
  input  wire logic        external_start_n
);

  // ***********************************
  // declarations
  // ***********************************
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_PACE = 3'b010,
    SQ_CONV = 3'b100
  } adcsq_state_t;

  adcsq_state_t state;
  adcsq_state_t next_state;

  logic [15:0] acquisition_control_status;
  logic [15:0] channel_configuration;
  logic [15:0] rate_div;
  logic [15:0] timer_period;
  logic        data_ready;
  logic [9:0]  pos;
  logic [9:0]  next_pos;
  logic [15:0] pace_cnt;
  logic [15:0] ram [0:2047];
  logic        gain_ram [0:63];
  logic        trig;
  logic        drain;

  // ***********************************
  // address decode
  // ***********************************
  wire [10:0] host_w  = reg_addr[11:1];
  wire [5:0]  gain_ix = reg_addr[6:1];

  // exact match of a register offset
  function automatic logic at_ofs(input logic [15:0] a,
                                  input logic [15:0] ofs);
    return a == ofs;
  endfunction : at_ofs

  wire hit_csr   = at_ofs(reg_addr, adcsq_pkg::OFS_CSR);
  wire hit_ccr   = at_ofs(reg_addr, adcsq_pkg::OFS_CCR);
  wire hit_rate  = at_ofs(reg_addr, adcsq_pkg::OFS_RATE);
  wire hit_start = at_ofs(reg_addr, adcsq_pkg::OFS_START);
  wire hit_timer = at_ofs(reg_addr, adcsq_pkg::OFS_TIMER);
  wire hit_gain  = (reg_addr[15:7] == adcsq_pkg::GAIN_PAGE)
                   && !reg_addr[0];
  wire hit_ram   = (reg_addr[15:12] == adcsq_pkg::RAM_TOP)
                   && (reg_addr[11:7] != adcsq_pkg::LOW_PAGE)
                   && !reg_addr[0];

  wire wr_csr   = reg_wr && hit_csr;
  wire wr_ccr   = reg_wr && hit_ccr;
  wire wr_rate  = reg_wr && hit_rate;
  wire wr_start = reg_wr && hit_start;
  wire wr_timer = reg_wr && hit_timer;
  wire wr_gain  = reg_wr && hit_gain;
  wire wr_ram   = reg_wr && hit_ram;

  // ***********************************
  // configuration decode
  // ***********************************
  wire [2:0] buf_code  = channel_configuration[adcsq_pkg::CCR_BUF_LO +: 3];
  wire [2:0] blk_code  = channel_configuration[adcsq_pkg::CCR_BLK_LO +: 3];
  wire [2:0] grp_code  = channel_configuration[adcsq_pkg::CCR_GRP_LO +: 3];
  wire [1:0] mode      = channel_configuration[adcsq_pkg::CCR_MODE_LO +: 2];
  wire       auto_gain = channel_configuration[adcsq_pkg::CCR_AGAIN];
  wire       fixed_x10 = channel_configuration[adcsq_pkg::CCR_X10];
  wire       twos_comp = acquisition_control_status[adcsq_pkg::CSR_CODE];
  wire       tmr_sel   = acquisition_control_status[adcsq_pkg::CSR_TMR];
  wire       ext_sel   = acquisition_control_status[adcsq_pkg::CSR_EXT];

  // ***********************************
  // scan geometry
  // ***********************************
  wire       is_auto  = (mode == adcsq_pkg::MODE_AUTO);
  wire       is_single = (mode == adcsq_pkg::MODE_SINGLE);
  wire [9:0] last_pos = adcsq_pkg::buf_last(buf_code);
  wire [5:0] mask     = adcsq_pkg::blk_mask(blk_code);
  wire [5:0] first_ch = {grp_code, 3'b000} & ~mask;
  wire [5:0] scan_ch  = first_ch | (pos[5:0] & mask);
  wire [15:0] pace_len = (rate_div == 16'h0000)
                         ? adcsq_pkg::DEF_PACE : rate_div;

  wire adcsq_pkg::adcsq_trig_t trig_sel =
      tmr_sel ? adcsq_pkg::TRG_TMR :
      (ext_sel ? adcsq_pkg::TRG_EXT
               : adcsq_pkg::TRG_SW);

  // gain for the channel being launched
  wire sel_gain = auto_gain
                  ? gain_ram[scan_ch]
                  : fixed_x10;

  // ***********************************
  // result formatting
  // ***********************************
  wire [15:0] fmt_data = twos_comp
                         ? conv_data ^ adcsq_pkg::MSB_FLIP
                         : conv_data;

  wire [10:0] buf_w  = adcsq_pkg::BUF_BASE_W + {1'b0, pos};
  wire        stored = (state == SQ_CONV) && conv_done;
  wire        at_end = (pos == last_pos);
  wire        idle   = (state == SQ_IDLE);

  // single scans only start from an idle, armed sequencer
  wire launch = idle && is_single && trig && !wr_ccr;
  wire pace_hit = (state == SQ_PACE) && (pace_cnt == 16'h0000)
                  && !drain;
  wire fire     = pace_hit && !wr_ccr;

  // ***********************************
  // aborted conversion drain
  // ***********************************
  // a launched conversion cannot be recalled; its late result
  // must not land in the scan that follows an abort
  wire drain_set = wr_ccr && (state == SQ_CONV) && !conv_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drain <= 1'b0;
    end else if (drain_set) begin
      drain <= 1'b1;
    end else if (conv_done) begin
      drain <= 1'b0;
    end
  end

  // ***********************************
  // trigger sources
  // ***********************************
  adcsq_trigger u_trigger (
    .clk              (clk),
    .rst              (rst),
    .external_start_n (external_start_n),
    .trig_sel         (trig_sel),
    .sw_start         (wr_start),
    .timer_period     (timer_period),
    .trig             (trig)
  );

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    next_state = state;
    next_pos   = pos;
    unique case (state)
      SQ_IDLE: begin
        if (is_auto) begin
          next_state = SQ_PACE;
        end else if (launch) begin
          next_state = SQ_PACE;
        end
      end
      SQ_PACE: begin
        if (pace_hit) begin
          next_state = SQ_CONV;
        end
      end
      SQ_CONV: begin
        if (conv_done) begin
          if (at_end) begin
            next_pos = 10'h000;
            next_state = is_single ? SQ_IDLE
                                   : SQ_PACE;
          end else begin
            next_pos   = pos + 10'h001;
            next_state = SQ_PACE;
          end
        end
      end
    endcase
    if (wr_ccr) begin
      next_state = SQ_IDLE;
      next_pos   = 10'h000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SQ_IDLE;
      pos   <= 10'h000;
    end else begin
      state <= next_state;
      pos   <= next_pos;
    end
  end

  // ***********************************
  // sample pacing
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pace_cnt <= 16'h0000;
    end else if (idle) begin
      pace_cnt <= 16'h0000;
    end else if (pace_hit) begin
      pace_cnt <= pace_len - 16'h0001;
    end else if (pace_cnt != 16'h0000) begin
      pace_cnt <= pace_cnt - 16'h0001;
    end
  end

  // ***********************************
  // converter launch
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start    <= 1'b0;
      conv_channel  <= 6'h00;
      conv_gain_x10 <= 1'b0;
    end else begin
      conv_start <= fire;
      if (fire) begin
        conv_channel  <= scan_ch;
        conv_gain_x10 <= sel_gain;
      end
    end
  end

  // ***********************************
  // control registers
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acquisition_control_status          <= adcsq_pkg::CSR_RST;
      channel_configuration          <= adcsq_pkg::CCR_RST;
      rate_div     <= 16'h0000;
      timer_period <= 16'h0000;
    end else begin
      if (wr_csr) begin
        acquisition_control_status <= reg_wdata;
      end
      if (wr_ccr) begin
        channel_configuration <= reg_wdata;
      end
      if (wr_rate) begin
        rate_div <= reg_wdata;
      end
      if (wr_timer) begin
        timer_period <= reg_wdata;
      end
    end
  end

  // data ready: set at buffer end, cleared by writing one
  wire rdy_set = stored && at_end;
  wire rdy_clr = wr_csr && reg_wdata[adcsq_pkg::CSR_RDY];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_ready <= 1'b0;
    end else if (rdy_set) begin
      data_ready <= 1'b1;
    end else if (rdy_clr) begin
      data_ready <= 1'b0;
    end
  end

  // ***********************************
  // on-board RAM and gain RAM
  // ***********************************
  // scan and host writes share the RAM; a host write to the same word in one cycle wins; host read never blocks scan
  always_ff @(posedge clk) begin
    if (stored) begin
      ram[buf_w] <= fmt_data;
    end
    if (wr_ram) begin
      ram[host_w] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_gain) begin
      gain_ram[gain_ix] <= reg_wdata[0];
    end
  end

  // ***********************************
  // read data, one cycle after the strobe
  // ***********************************
  wire [15:0] csr_view = {acquisition_control_status[15:8], data_ready, idle, acquisition_control_status[5:0]};
  wire [15:0] gain_view = {15'h0000, gain_ram[gain_ix]};

  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (hit_csr) begin
      next_rdata = csr_view;
    end else if (hit_ccr) begin
      next_rdata = channel_configuration;
    end else if (hit_rate) begin
      next_rdata = rate_div;
    end else if (hit_timer) begin
      next_rdata = timer_period;
    end else if (hit_gain) begin
      next_rdata = gain_view;
    end else if (hit_ram) begin
      next_rdata = ram[host_w];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : adcsq_sequencer

`default_nettype wire

// File: adcsq_trigger.sv
// trigger source selection: software start, external pin, interval timer
// assumes external_start_n is asynchronous; other inputs share clk
`timescale 1ns/1ps
`default_nettype none

module adcsq_trigger (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // pin
  input  wire logic               external_start_n,
  // control
  input  wire adcsq_pkg::adcsq_trig_t trig_sel,
  input  wire logic               sw_start,
  input  wire logic [15:0]        timer_period,
  // result
  output logic                    trig
);

  // ***********************************
  // external pin synchroniser
  // ***********************************
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_s3;
  logic [2:0] presc;
  logic [15:0] tcnt;
  logic       tmr_exp;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end else begin
      ext_s1 <= external_start_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  wire ext_fall = ext_s3 & ~ext_s2;

  // ***********************************
  // interval timer in 160 ns ticks
  // ***********************************
  wire tmr_on = (trig_sel == adcsq_pkg::TRG_TMR);
  wire tick   = (presc == 3'(adcsq_pkg::TMR_PRESC - 3'h1));
  wire ends   = tick && (tcnt <= 16'h0001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc   <= 3'h0;
      tcnt    <= 16'h0000;
      tmr_exp <= 1'b0;
    end else if (!tmr_on) begin
      presc   <= 3'h0;
      tcnt    <= timer_period;
      tmr_exp <= 1'b0;
    end else begin
      presc   <= tick ? 3'h0 : presc + 3'h1;
      tcnt    <= ends ? timer_period : (tick ? tcnt - 16'h0001 : tcnt);
      tmr_exp <= ends;
    end
  end

  // ***********************************
  // one source only
  // ***********************************
  always_comb begin
    unique case (trig_sel)
      adcsq_pkg::TRG_SW:  trig = sw_start;
      adcsq_pkg::TRG_EXT: trig = ext_fall;
      default:            trig = tmr_exp;
    endcase
  end

endmodule : adcsq_trigger

`default_nettype wire
